// >>> rtl/cbf_transmit_error_count_filter.sv
// Transmit error counter, bus-off handling and four-bank acceptance filter
`timescale 1ns/10ps
`default_nettype none

module cbf_transmit_error_count_filter (
    input  wire logic                      clk_sys,       // System clock, 100 MHz
    input  wire logic                      nrst,          // Async reset, active low
    input  wire logic [cbf_pkg::ADDR_W-1:0] reg_addr,     // Register address
    input  wire logic [cbf_pkg::DATA_W-1:0] reg_wdata,    // Register write data
    input  wire logic                      reg_wr,        // Write strobe
    input  wire logic                      reg_rd,        // Read strobe
    output logic      [cbf_pkg::DATA_W-1:0] reg_rdata,    // Read data, cycle after strobe
    output logic                           irq,           // Level interrupt
    input  wire logic                      tx_err_inc,    // Transmit error seen, add 8
    input  wire logic                      tx_ok_dec,     // Successful transmit, minus 1
    input  wire logic                      bus_free,      // 11 recessive bits seen
    input  wire logic                      rx_valid,      // Received frame ready to filter
    input  wire logic                      rx_ide,        // Frame is extended format
    input  wire logic                      rx_rtr,        // Frame is remote request
    input  wire logic [cbf_pkg::ID_W-1:0]  rx_id,         // Identifier, standard in low 11 bits
    input  wire logic [7:0]                rx_data0,      // First data byte
    input  wire logic [7:0]                rx_data1,      // Second data byte
    output logic                           rx_store,      // Push frame into receive_queue
    output logic      [2*cbf_pkg::NUM_BANKS-1:0] rx_hits, // Filters that matched
    output logic                           rec_clear,     // Clear receive_error_count
    output logic                           reset_mode,    // Reset mode active
    output logic                           bus_off,       // Bus-off active
    output logic                           node_active    // Node may take part on the bus
);
    import cbf_pkg::*;

    cbf_node_type           node_state;
    logic [7:0]             transmit_error_count;
    logic                   force_pending;
    logic                   err_warn;
    logic                   err_passive;
    logic [7:0]             filter_bank_mode;
    logic [7:0]             filter_enable;
    logic [WORD_W-1:0]      acceptance_code_regs [NUM_BANKS];
    logic [WORD_W-1:0]      acceptance_mask_regs [NUM_BANKS];
    logic [INT_W-1:0]       int_status;
    logic [INT_W-1:0]       int_mask;
    logic [INT_W-1:0]       int_event;

    logic                   wr_mode;
    logic                   wr_tec;
    logic                   leave_reset;
    logic                   hw_busoff;
    logic                   busoff_entry;
    logic                   recover_done;
    logic                   next_warn;
    logic                   next_passive;
    logic [WORD_W-1:0]      rx_word;
    logic [WORD_W-1:0]      care;
    logic                   rx_ok_fmt;
    logic [2*NUM_BANKS-1:0] next_hits;
    logic                   code_sel;
    logic [1:0]             code_bank;
    logic [1:0]             code_byte;
    logic                   code_wr_ok;

    assign wr_mode      = reg_wr && (reg_addr == ADDR_MODE);
    assign wr_tec       = reg_wr && (reg_addr == ADDR_TRANSMIT_ERROR_COUNT) && reset_mode;
    assign leave_reset  = wr_mode && reset_mode && !reg_wdata[MODE_RESET_BIT];
    assign hw_busoff    = !reset_mode && (node_state == CBF_ACTIVE) && tx_err_inc
                          && (transmit_error_count >= TEC_OVF);
    assign busoff_entry = hw_busoff || (leave_reset && force_pending);
    assign recover_done = !reset_mode && (node_state == CBF_BUSOFF) && bus_free
                          && (transmit_error_count == TEC_RESET);

    assign bus_off      = (node_state == CBF_BUSOFF);
    assign node_active  = !reset_mode && (node_state == CBF_ACTIVE);

    // Reset mode; bus-off puts the controller back into it
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            reset_mode <= 1'b1;
        end else if (busoff_entry) begin
            reset_mode <= 1'b1;
        end else if (wr_mode) begin
            reset_mode <= reg_wdata[MODE_RESET_BIT];
        end
    end

    // Counter and bus-off state
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            transmit_error_count <= TEC_RESET;
            node_state           <= CBF_ACTIVE;
            force_pending        <= 1'b0;
        end else if (busoff_entry) begin
            transmit_error_count <= TEC_BUSOFF;
            node_state           <= CBF_BUSOFF;
            force_pending        <= 1'b0;
        end else if (wr_tec) begin
            transmit_error_count <= reg_wdata;
            force_pending        <= (reg_wdata == TEC_FORCE);
            if (node_state == CBF_BUSOFF && reg_wdata != TEC_FORCE) begin
                node_state <= CBF_WAIT_FREE;
            end
        end else if (!reset_mode) begin
            // In reset mode nothing below runs, so recovery stays frozen
            case (node_state)
                CBF_ACTIVE: begin
                    if (tx_err_inc) begin
                        transmit_error_count <= transmit_error_count + TEC_STEP;
                    end else if (tx_ok_dec && transmit_error_count != TEC_RESET) begin
                        transmit_error_count <= transmit_error_count - TEC_ONE;
                    end
                end
                CBF_BUSOFF: begin
                    if (bus_free) begin
                        if (transmit_error_count == TEC_RESET) begin
                            node_state <= CBF_ACTIVE;
                        end else begin
                            transmit_error_count <= transmit_error_count - TEC_ONE;
                        end
                    end
                end
                CBF_WAIT_FREE: begin
                    if (bus_free) begin
                        node_state <= CBF_ACTIVE;
                    end
                end
                default: begin
                    node_state <= CBF_ACTIVE;
                end
            endcase
        end
    end

    // Receive counter cleared alongside bus-off entry
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            rec_clear <= 1'b0;
        end else begin
            rec_clear <= busoff_entry;
        end
    end

    // Error levels only follow the counter in operation, so a CPU value
    // written in reset mode shows up after the mode is left
    assign next_warn    = (transmit_error_count >= TEC_WARN);
    assign next_passive = (transmit_error_count >= TEC_PASSIVE);

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            err_warn    <= 1'b0;
            err_passive <= 1'b0;
        end else if (!reset_mode) begin
            err_warn    <= next_warn;
            err_passive <= next_passive;
        end
    end

    always_comb begin
        int_event              = INT_RST;
        int_event[INT_BUSOFF]  = busoff_entry;
        int_event[INT_WARN]    = !reset_mode && (next_warn != err_warn);
        int_event[INT_PASSIVE] = !reset_mode && (next_passive != err_passive);
        int_event[INT_RECOVER] = recover_done;
    end

    // Sticky flags; a new event beats a write-one clear
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            int_status <= INT_RST;
        end else if (reg_wr && reg_addr == ADDR_INT_STAT) begin
            int_status <= (int_status & ~reg_wdata[INT_W-1:0]) | int_event;
        end else begin
            int_status <= int_status | int_event;
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            int_mask <= INT_RST;
        end else if (reg_wr && reg_addr == ADDR_INT_MASK) begin
            int_mask <= reg_wdata[INT_W-1:0];
        end
    end

    assign irq = |(int_status & int_mask);

    // Filter mode and enable registers
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            filter_bank_mode <= FILT_MODE_RST;
        end else if (reg_wr && reg_addr == ADDR_FILT_MODE && reset_mode) begin
            filter_bank_mode <= reg_wdata;
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            filter_enable <= FILT_EN_RST;
        end else if (reg_wr && reg_addr == ADDR_FILT_EN) begin
            filter_enable <= reg_wdata;
        end
    end

    // Code and mask bytes: 8 bytes per bank, code first, byte 0 is the top
    assign code_sel  = (reg_addr >= ADDR_CODE_BASE) && (reg_addr <= ADDR_CODE_LAST);
    assign code_bank = reg_addr[BANK_SHIFT+1:BANK_SHIFT];
    assign code_byte = reg_addr[1:0];

    // A filter may only be changed while it is disabled, so it never
    // matches against a half-written pattern
    always_comb begin
        if (!code_byte[1] || filter_bank_mode[2*code_bank]) begin
            code_wr_ok = !filter_enable[2*code_bank];
        end else begin
            code_wr_ok = !filter_enable[2*code_bank+1];
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            for (int b = 0; b < NUM_BANKS; b++) begin
                acceptance_code_regs[b] <= WORD_RST;
                acceptance_mask_regs[b] <= WORD_RST;
            end
        end else if (reg_wr && code_sel && code_wr_ok) begin
            if (reg_addr[MASK_SEL_BIT]) begin
                acceptance_mask_regs[code_bank][(3-code_byte)*8 +: 8] <= reg_wdata;
            end else begin
                acceptance_code_regs[code_bank][(3-code_byte)*8 +: 8] <= reg_wdata;
            end
        end
    end

    // Received word laid out like the code registers
    always_comb begin
        if (rx_ide) begin
            rx_word = {rx_id, rx_rtr, 2'b00};
            care    = EFF_CARE;
        end else begin
            rx_word = {rx_id[SFF_ID_W-1:0], rx_rtr, 4'h0, rx_data0, rx_data1};
            care    = SFF_CARE;
        end
    end

    generate
        for (genvar b = 0; b < NUM_BANKS; b++) begin : g_bank
            logic              fmt_ext;
            logic              single;
            logic [WORD_W-1:0] diff;
            logic [HALF_W-1:0] diff2;
            assign fmt_ext = filter_bank_mode[2*b+1];
            assign single  = filter_bank_mode[2*b];
            // Set mask bits are ignored
            assign diff  = (rx_word ^ acceptance_code_regs[b]) & ~acceptance_mask_regs[b] & care;
            assign diff2 = (rx_word[WORD_W-1:HALF_W] ^ acceptance_code_regs[b][HALF_W-1:0])
                           & ~acceptance_mask_regs[b][HALF_W-1:0] & care[WORD_W-1:HALF_W];
            always_comb begin
                if (single) begin
                    next_hits[2*b]   = filter_enable[2*b] && (fmt_ext == rx_ide) && (diff == '0);
                    next_hits[2*b+1] = 1'b0;
                end else begin
                    next_hits[2*b]   = filter_enable[2*b] && (fmt_ext == rx_ide)
                                       && (diff[WORD_W-1:HALF_W] == '0);
                    next_hits[2*b+1] = filter_enable[2*b+1] && (fmt_ext == rx_ide) && (diff2 == '0);
                end
            end
        end
    endgenerate

    assign rx_ok_fmt = |next_hits;

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            rx_store <= 1'b0;
            rx_hits  <= '0;
        end else begin
            rx_store <= rx_valid && rx_ok_fmt;
            rx_hits  <= rx_valid ? next_hits : '0;
        end
    end

    // Register read port
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            reg_rdata <= '0;
        end else if (reg_rd) begin
            if (code_sel) begin
                reg_rdata <= reg_addr[MASK_SEL_BIT]
                           ? acceptance_mask_regs[code_bank][(3-code_byte)*8 +: 8]
                           : acceptance_code_regs[code_bank][(3-code_byte)*8 +: 8];
            end else begin
                case (reg_addr)
                    ADDR_MODE:      reg_rdata <= {7'h00, reset_mode};
                    ADDR_STATUS:    reg_rdata <= {3'h0, node_state == CBF_WAIT_FREE, force_pending,
                                                  err_passive, err_warn, bus_off};
                    ADDR_INT_STAT:  reg_rdata <= {4'h0, int_status};
                    ADDR_INT_MASK:  reg_rdata <= {4'h0, int_mask};
                    ADDR_TRANSMIT_ERROR_COUNT:     reg_rdata <= transmit_error_count;
                    ADDR_FILT_MODE: reg_rdata <= filter_bank_mode;
                    ADDR_FILT_EN:   reg_rdata <= filter_enable;
                    default:        reg_rdata <= '0;
                endcase
            end
        end else begin
            reg_rdata <= '0;
        end
    end

    // Checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);

    chk_tec_ro_oper: assert property (
        (reg_wr && reg_addr == ADDR_TRANSMIT_ERROR_COUNT && !reset_mode && !tx_err_inc && !tx_ok_dec && !bus_free)
        |=> $stable(transmit_error_count))
        else $error("counter changed by a write outside reset mode");

    chk_busoff_load: assert property (
        busoff_entry |=> (transmit_error_count == TEC_BUSOFF) && bus_off && reset_mode)
        else $error("bus-off did not load 127 and enter reset mode");

    chk_write_clears_bo: assert property (
        (wr_tec && bus_off && reg_wdata != TEC_FORCE) |=> !bus_off && node_state == CBF_WAIT_FREE)
        else $error("write during bus-off did not clear it");

    chk_force_busoff: assert property (
        (leave_reset && force_pending)
        |=> bus_off && reset_mode && rec_clear && transmit_error_count == TEC_BUSOFF)
        else $error("write of 255 did not force bus-off on leaving reset");

    chk_status_hold: assert property (
        (reset_mode && $past(reset_mode)) |-> $stable(err_warn) && $stable(err_passive))
        else $error("error levels changed in reset mode");

    chk_rec_clear: assert property (
        busoff_entry |=> rec_clear ##1 !rec_clear || busoff_entry)
        else $error("receive counter clear missing");

    chk_freeze_recov: assert property (
        (bus_off && reset_mode && !wr_tec && !busoff_entry) |=> bus_off && $stable(transmit_error_count))
        else $error("recovery not frozen in reset mode");

    chk_recov_step: assert property (
        (bus_off && !reset_mode && bus_free && transmit_error_count != TEC_RESET)
        |=> transmit_error_count == $past(transmit_error_count) - TEC_ONE)
        else $error("recovery step wrong");

    chk_recov_end: assert property (
        recover_done |=> !bus_off && int_status[INT_RECOVER])
        else $error("recovery did not end at zero");

    chk_store_hit: assert property (
        rx_store |-> (rx_hits != '0) && $past(rx_valid))
        else $error("frame stored without a matching filter");

    chk_mode_ro: assert property (
        (reg_wr && reg_addr == ADDR_FILT_MODE && !reset_mode) |=> $stable(filter_bank_mode))
        else $error("filter mode written outside reset mode");

    chk_single_f2: assert property (
        (rx_valid && filter_bank_mode[0]) |=> !rx_hits[1])
        else $error("second filter hit in single mode");

    cov_hw_busoff:  cover property (hw_busoff ##[1:20] leave_reset);
    cov_recover:    cover property (recover_done);
    cov_force:      cover property (leave_reset && force_pending);
    cov_store:      cover property (rx_store && rx_hits[3]);
endmodule

`default_nettype wire

// >>> rtl/cbf_pkg.sv
// Constants and types for the transmit error counter and acceptance filter block
package cbf_pkg;
    localparam int          ADDR_W         = 8;
    localparam int          DATA_W         = 8;
    localparam int          NUM_BANKS      = 4;
    localparam int          WORD_W         = 32;
    localparam int          HALF_W         = 16;
    localparam int          ID_W           = 29;
    localparam int          SFF_ID_W       = 11;

    // Register map
    localparam logic [7:0]  ADDR_MODE      = 8'h00;
    localparam logic [7:0]  ADDR_STATUS    = 8'h02;
    localparam logic [7:0]  ADDR_INT_STAT  = 8'h03;
    localparam logic [7:0]  ADDR_INT_MASK  = 8'h04;
    localparam logic [7:0]  ADDR_TRANSMIT_ERROR_COUNT     = 8'h0F;
    localparam logic [7:0]  ADDR_FILT_MODE = 8'h1D;
    localparam logic [7:0]  ADDR_FILT_EN   = 8'h1E;
    localparam logic [7:0]  ADDR_CODE_BASE = 8'h20;
    localparam logic [7:0]  ADDR_CODE_LAST = 8'h3F;
    localparam int          BANK_SHIFT     = 3;
    localparam int          MASK_SEL_BIT   = 2;

    // Reset values and counter limits
    localparam logic [7:0]  TEC_RESET      = 8'h00;
    localparam logic [7:0]  TEC_BUSOFF     = 8'h7F;
    localparam logic [7:0]  TEC_FORCE      = 8'hFF;
    localparam logic [7:0]  TEC_STEP       = 8'h08;
    localparam logic [7:0]  TEC_ONE        = 8'h01;
    localparam logic [7:0]  TEC_OVF        = 8'hF8;
    localparam logic [7:0]  TEC_WARN       = 8'h60;
    localparam logic [7:0]  TEC_PASSIVE    = 8'h80;
    localparam logic [7:0]  FILT_MODE_RST  = 8'h00;
    localparam logic [7:0]  FILT_EN_RST    = 8'h00;
    localparam logic [31:0] WORD_RST       = 32'h0000_0000;

    // Field positions
    localparam int          MODE_RESET_BIT = 0;
    localparam int          INT_W          = 4;
    localparam int          INT_BUSOFF     = 0;
    localparam int          INT_WARN       = 1;
    localparam int          INT_PASSIVE    = 2;
    localparam int          INT_RECOVER    = 3;
    localparam logic [3:0]  INT_RST        = 4'h0;

    // Bits of the received word that take part in a compare
    localparam logic [31:0] SFF_CARE       = 32'hFFF0_FFFF;
    localparam logic [31:0] EFF_CARE       = 32'hFFFF_FFFC;

    typedef enum logic [1:0] {
        CBF_ACTIVE    = 2'b00,
        CBF_BUSOFF    = 2'b01,
        CBF_WAIT_FREE = 2'b10
    } cbf_node_type;
endpackage

// >>> verif/cbf_bus_model.sv
// CAN bus side model: error, bus-free and received-frame events
`timescale 1ns/10ps
`default_nettype none

module cbf_bus_model (
    input  wire logic        clk_sys,    // System clock
    output logic             tx_err_inc, // Transmit error event
    output logic             tx_ok_dec,  // Transmit success event
    output logic             bus_free,   // Bus idle event
    output logic             rx_valid,   // Frame strobe
    output logic             rx_ide,     // Extended frame
    output logic             rx_rtr,     // Remote frame
    output logic [28:0]      rx_id,      // Identifier
    output logic [7:0]       rx_data0,   // Data byte 0
    output logic [7:0]       rx_data1    // Data byte 1
);
    initial begin
        {tx_err_inc, tx_ok_dec, bus_free, rx_valid, rx_ide, rx_rtr} = 6'h00;
        {rx_id, rx_data0, rx_data1} = 45'h0;
    end

    // Select order {err, ok, free}; a gap cycle after each event pulse
    task automatic events(input logic [2:0] sel, input int n);
        repeat (n) begin
            @(posedge clk_sys) {tx_err_inc, tx_ok_dec, bus_free} <= sel;
            @(posedge clk_sys) {tx_err_inc, tx_ok_dec, bus_free} <= 3'h0;
        end
    endtask

    // Lines released after a frame show inverted values, never a stale copy
    task automatic frame(input logic ide, input logic [28:0] id, input logic [15:0] data);
        @(posedge clk_sys);
        rx_valid <= 1'b1;
        rx_ide <= ide;
        rx_id <= id;
        {rx_data0, rx_data1} <= data;
        @(posedge clk_sys);
        rx_valid <= 1'b0;
        rx_ide <= ~ide;
        rx_id <= ~id;
        {rx_data0, rx_data1} <= ~data;
    endtask
endmodule

`default_nettype wire

// >>> verif/cbf_transmit_error_count_filter_tb.sv
// Self-checking bench for the transmit error counter and acceptance filter
`timescale 1ns/10ps
`default_nettype none

module cbf_transmit_error_count_filter_tb;
    import cbf_pkg::*;
    logic        clk_sys, nrst, reg_wr, reg_rd, irq, rx_store, rec_clear, reset_mode, bus_off, node_active;
    logic        tx_err_inc, tx_ok_dec, bus_free, rx_valid, rx_ide, rx_rtr;
    logic [7:0]  reg_addr, reg_wdata, reg_rdata, rx_hits, rx_data0, rx_data1;
    logic [28:0] rx_id;
    logic [3:0]  st;
    int          fails = 0;
    int          compares = 0;

    assign st = {reset_mode, bus_off, node_active, irq};

    cbf_transmit_error_count_filter cbf_transmit_error_count_filter_inst (.clk_sys, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .irq, .tx_err_inc, .tx_ok_dec, .bus_free, .rx_valid, .rx_ide, .rx_rtr, .rx_id,
        .rx_data0, .rx_data1, .rx_store, .rx_hits, .rec_clear, .reset_mode, .bus_off, .node_active);
    cbf_bus_model cbf_bus_model_inst (.clk_sys, .tx_err_inc, .tx_ok_dec, .bus_free, .rx_valid,
        .rx_ide, .rx_rtr, .rx_id, .rx_data0, .rx_data1);

    always #5 clk_sys = ~clk_sys;

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask

    // Read data stands only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk_sys);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, exp);
    endtask

    // Byte 0 carries the top bits of the word
    task automatic wr_word(input logic [7:0] a, input logic [31:0] w);
        for (int i = 0; i < 4; i++) wr(a + 8'(i), w[31-8*i -: 8]);
    endtask

    task automatic fr(input logic ide, input logic [28:0] id, input logic [15:0] d, input logic [7:0] exp);
        cbf_bus_model_inst.frame(ide, id, d);
        #1 chk(rx_hits, exp);
        chk(rx_store, exp != 8'h00);
    endtask

    task automatic end_of_test();
        $display("Checks: compares=%0d fails=%0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    initial begin
        #100000;
        fails++;
        end_of_test();
    end

    initial begin
        {clk_sys, nrst, reg_wr, reg_rd, reg_addr, reg_wdata} = 20'h0;
        repeat (3) @(posedge clk_sys);
        nrst <= 1'b1;
        #1 chk(st, 4'h8);
        rd(ADDR_TRANSMIT_ERROR_COUNT, TEC_RESET);
        rd(ADDR_FILT_MODE, 8'h00);
        rd(8'h01, 8'h00);
        fr(1'b0, 29'h123, 16'hAA55, 8'h00);
        // Bank 0 single standard, bank 1 dual extended
        wr(ADDR_FILT_MODE, 8'h09);
        rd(ADDR_FILT_MODE, 8'h09);
        wr_word(ADDR_CODE_BASE, 32'h2460_AA55);
        wr_word(8'h24, 32'h0000_FFFF);
        wr_word(8'h28, 32'h91A2_0000);
        wr_word(8'h2C, 32'h0000_FFFF);
        wr(ADDR_FILT_EN, 8'h0D);
        wr(ADDR_TRANSMIT_ERROR_COUNT, 8'hFA);
        rd(ADDR_TRANSMIT_ERROR_COUNT, 8'hFA);
        wr(ADDR_INT_MASK, 8'h01);
        wr(ADDR_MODE, 8'h00);
        #1 chk(st, 4'h2);
        wr(ADDR_FILT_MODE, 8'hFF);
        wr(ADDR_TRANSMIT_ERROR_COUNT, 8'h03);
        rd(ADDR_FILT_MODE, 8'h09);
        rd(ADDR_TRANSMIT_ERROR_COUNT, 8'hFA);
        fr(1'b0, 29'h123, 16'hAA55, 8'h01);
        fr(1'b0, 29'h123, 16'h0011, 8'h01);
        fr(1'b0, 29'h122, 16'hAA55, 8'h00);
        fr(1'b1, 29'h123, 16'hAA55, 8'h08);
        fr(1'b1, 29'h1234_5678, 16'h0000, 8'h0C);
        wr(ADDR_FILT_EN, 8'h0E);
        fr(1'b0, 29'h123, 16'hAA55, 8'h00);
        cbf_bus_model_inst.events(3'b010, 1);
        rd(ADDR_TRANSMIT_ERROR_COUNT, 8'hF9);
        cbf_bus_model_inst.events(3'b100, 1);
        #1 chk({st, rec_clear}, 5'h1B);
        rd(ADDR_TRANSMIT_ERROR_COUNT, TEC_BUSOFF);
        wr(ADDR_INT_MASK, 8'h00);
        #1 chk(irq, 1'b0);
        wr(ADDR_INT_MASK, 8'h01);
        #1 chk(irq, 1'b1);
        wr(ADDR_INT_STAT, 8'h01);
        #1 chk(irq, 1'b0);
        wr(ADDR_MODE, 8'h00);
        cbf_bus_model_inst.events(3'b001, 10);
        rd(ADDR_TRANSMIT_ERROR_COUNT, 8'h75);
        wr(ADDR_MODE, 8'h01);
        cbf_bus_model_inst.events(3'b001, 5);
        rd(ADDR_TRANSMIT_ERROR_COUNT, 8'h75);
        #1 chk(st, 4'hC);
        wr(ADDR_MODE, 8'h00);
        cbf_bus_model_inst.events(3'b001, 117);
        rd(ADDR_TRANSMIT_ERROR_COUNT, 8'h00);
        #1 chk(bus_off, 1'b1);
        cbf_bus_model_inst.events(3'b001, 1);
        #1 chk(st, 4'h2);
        rd(ADDR_INT_STAT, 8'h0E);
        wr(ADDR_MODE, 8'h01);
        wr(ADDR_TRANSMIT_ERROR_COUNT, TEC_FORCE);
        #1 chk(st, 4'h8);
        rd(ADDR_STATUS, 8'h08);
        wr(ADDR_MODE, 8'h00);
        #1 chk({st, rec_clear}, 5'h1B);
        rd(ADDR_TRANSMIT_ERROR_COUNT, TEC_BUSOFF);
        wr(ADDR_TRANSMIT_ERROR_COUNT, 8'h10);
        #1 chk(bus_off, 1'b0);
        wr(ADDR_INT_STAT, 8'h01);
        wr(ADDR_MODE, 8'h00);
        #1 chk(st, 4'h0);
        cbf_bus_model_inst.events(3'b001, 1);
        #1 chk(st, 4'h2);
        end_of_test();
    end
endmodule

`default_nettype wire
